//--- design/cbs_pkg.sv
// shared types and constants for the bus cycle sequencer
package cbs_pkg;

    // ***************************************************************
    // instruction classes seen by the sequencer
    // ***************************************************************
    typedef enum logic [1:0] {
        GRP_BRANCH_D8,   // conditional branch, 8-bit displacement
        GRP_BRANCH_D16,  // any branch, 16-bit displacement
        GRP_BIT_REG,     // bit operation on a register operand
        GRP_BIT_MEM      // bit operation on a memory operand
    } cbs_group_t;

    // memory operand addressing for bit operations
    typedef enum logic [1:0] {
        MODE_POINTER,    // via pointer_register
        MODE_ABS8,       // 8-bit absolute
        MODE_ABS16,      // 16-bit absolute, one extra word
        MODE_ABS32       // 32-bit absolute, two extra words
    } cbs_mode_t;

    // ***************************************************************
    // one step of an instruction's cycle sequence
    // ***************************************************************
    typedef enum logic [3:0] {
        STEP_RD_NEXT,       // word read, next instruction
        STEP_RD_NEXT_LOCK,  // word read, next instruction, locked
        STEP_RD_2ND,        // word read, 2nd instruction word
        STEP_RD_3RD,        // word read, 3rd instruction word
        STEP_RD_4TH,        // word read, 4th instruction word
        STEP_RD_EA_W,       // word read, branch target
        STEP_RD_EA_B,       // byte read, operand_address
        STEP_RD_EA_B_LOCK,  // byte read, operand_address, locked
        STEP_WR_EA_B,       // byte write, operand_address
        STEP_INTERNAL,      // one internal state, no bus access
        STEP_END            // sequence complete
    } cbs_step_t;

    // target address selector codes
    localparam logic [2:0] TGT_NEXT = 3'h0;
    localparam logic [2:0] TGT_EA = 3'h1;
    localparam logic [2:0] TGT_2ND = 3'h2;
    localparam logic [2:0] TGT_3RD = 3'h3;
    localparam logic [2:0] TGT_4TH = 3'h4;

    // step index width and reset values
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;
    localparam logic [2:0] TGT_RESET = TGT_NEXT;

    // extra address words per mode
    localparam logic [IDX_W-1:0] EXT_ABS16 = 3'h1;
    localparam logic [IDX_W-1:0] EXT_ABS32 = 3'h2;
    localparam logic [IDX_W-1:0] EXT_NONE = 3'h0;

endpackage

//--- design/cbs_cpu_bus_cycle_sequencer.sv
// bus cycle sequencer: issues the ordered bus cycles of each instruction
`timescale 1ns/1ps

// Operation
// - short conditional branch: prefetch next word, then word read at target.
// - always-taken long branch: 2nd word, one internal state, target read.
// - never-taken and conditional long branches use the identical three steps.
// - immediate bit number on register operand: only the next-word prefetch.
// - register bit number on register operand: only the next-word prefetch.
// - clear/set/invert/store via pointer: 2nd, locked byte, locked next, byte write.
// - test/load/logic via pointer: 2nd, byte read, locked next, no write.
// - 8-bit absolute forms follow their pointer counterparts exactly.
// - 16-bit absolute adds 3rd-word read before the operand access.
// - 32-bit absolute reads 2nd, 3rd, 4th words; modify forms total six cycles.
// - inverted store is read-modify-write; inverted logic forms are read-only.
// - bus stays held after a locked cycle until the next cycle begins, unless it was the instruction's last.
// - cycle type is byte/word read/write; target is next, operand or word number.
module cbs_cpu_bus_cycle_sequencer
    import cbs_pkg::*;
(
    input wire logic clk_sys,          // system clock, 125 MHz
    input wire logic nrst,             // synchronous reset, active low
    input wire logic instrValid,       // instruction ready for sequencing
    input wire cbs_group_t instrGroup, // instruction class
    input wire logic instrRmw,         // bit op writes memory back
    input wire cbs_mode_t instrMode,   // memory addressing mode
    input wire logic busDone,          // bus controller ends current cycle
    output logic instrAccept,          // pulse: instruction taken
    output logic busReq,               // bus cycle requested
    output logic busWrite,             // 1 write, 0 read
    output logic busWord,              // 1 word size, 0 byte size
    output logic [2:0] busTarget,      // target address selector
    output logic busLock,              // bus must not be released
    output logic internalOp,           // internal state, no bus access
    output logic seqBusy,              // sequence in progress
    output logic instrDone             // pulse: last cycle finished
);

    // ***************************************************************
    // helper functions
    // ***************************************************************

    // extension words between the 2nd word and the operand access
    function automatic logic [IDX_W-1:0] extWords(input cbs_mode_t mode);
        logic [IDX_W-1:0] n;
        n = EXT_NONE;
        // pointer and short absolute forms carry no extension word
        unique case (mode)
            MODE_ABS16: n = EXT_ABS16;
            MODE_ABS32: n = EXT_ABS32;
            MODE_POINTER, MODE_ABS8: n = EXT_NONE;
        endcase
        return n;
    endfunction

    // step at a given position of an instruction's sequence
    // the sequence is a pure function of the latched class and a step index,
    // so a long wait on one cycle never disturbs the order of the rest;
    // an index past the last step of a class reads as the end marker
    function automatic cbs_step_t stepAt(
        input cbs_group_t grp,
        input logic rmw,
        input cbs_mode_t mode,
        input logic [IDX_W-1:0] idx
    );
        cbs_step_t s;
        logic [IDX_W-1:0] ext;
        s = STEP_END;
        ext = extWords(mode);
        unique case (grp)
            GRP_BRANCH_D8: begin
                // taken or not, the target word is still fetched
                if (idx == IDX_RESET) begin
                    s = STEP_RD_NEXT;
                end else if (idx == IDX_ONE) begin
                    s = STEP_RD_EA_W;
                end
            end
            GRP_BRANCH_D16: begin
                // condition outcome is not an input: shape never varies
                if (idx == IDX_RESET) begin
                    s = STEP_RD_2ND;
                end else if (idx == IDX_ONE) begin
                    s = STEP_INTERNAL;
                end else if (idx == 3'h2) begin
                    s = STEP_RD_EA_W;
                end
            end
            GRP_BIT_REG: begin
                if (idx == IDX_RESET) begin
                    s = STEP_RD_NEXT;
                end
            end
            GRP_BIT_MEM: begin
                if (idx == IDX_RESET) begin
                    s = STEP_RD_2ND;
                end else if (idx <= ext) begin
                    // extension words come before any operand access
                    s = (idx == IDX_ONE) ? STEP_RD_3RD : STEP_RD_4TH;
                end else if (idx == ext + IDX_ONE) begin
                    s = rmw ? STEP_RD_EA_B_LOCK : STEP_RD_EA_B;
                end else if (idx == ext + 3'h2) begin
                    s = STEP_RD_NEXT_LOCK;
                end else if (idx == ext + 3'h3 && rmw) begin
                    s = STEP_WR_EA_B;
                end
            end
        endcase
        return s;
    endfunction

    // bus target of a step
    function automatic logic [2:0] stepTarget(input cbs_step_t s);
        logic [2:0] t;
        t = TGT_NEXT;
        unique case (s)
            STEP_RD_2ND: t = TGT_2ND;
            STEP_RD_3RD: t = TGT_3RD;
            STEP_RD_4TH: t = TGT_4TH;
            STEP_RD_EA_W, STEP_RD_EA_B, STEP_RD_EA_B_LOCK, STEP_WR_EA_B: t = TGT_EA;
            default: t = TGT_NEXT; // next-word reads, internal, end
        endcase
        return t;
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    // the state code has a spare value; the default arm recovers from it
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUS,
        ST_INTERNAL
    } cbs_state_t;

    // latched class of the running instruction and its step index
    cbs_state_t state_q, state_d;
    cbs_group_t group_q, group_d;
    cbs_mode_t mode_q, mode_d;
    logic rmw_q, rmw_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic accept_q, accept_d;
    logic req_q, req_d;
    logic write_q, write_d;
    logic word_q, word_d;
    logic [2:0] target_q, target_d;
    logic lock_q, lock_d;
    logic intOp_q, intOp_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    cbs_step_t nextStep;

    // ***************************************************************
    // next-state logic
    // ***************************************************************

    // step that follows the current one, or the first of a new instruction
    always_comb begin
        if (state_q == ST_IDLE) begin
            nextStep = stepAt(instrGroup, instrRmw, instrMode, IDX_RESET);
        end else begin
            nextStep = stepAt(group_q, rmw_q, mode_q, idx_q + IDX_ONE);
        end
    end

    // sequencing; a new step is launched in the same edge the old one ends
    always_comb begin
        logic launch;
        launch = 1'b0;
        state_d = state_q;
        group_d = group_q;
        mode_d = mode_q;
        rmw_d = rmw_q;
        idx_d = idx_q;
        accept_d = 1'b0;
        req_d = req_q;
        write_d = write_q;
        word_d = word_q;
        target_d = target_q;
        lock_d = lock_q;
        intOp_d = 1'b0;
        done_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // offers are only looked at while idle; offers while busy are ignored
                if (instrValid) begin
                    group_d = instrGroup;
                    mode_d = instrMode;
                    rmw_d = instrRmw;
                    idx_d = IDX_RESET;
                    accept_d = 1'b1;
                    launch = 1'b1;
                end
            end
            ST_BUS: begin
                // cycle length is owned by the bus controller
                if (busDone) begin
                    idx_d = idx_q + IDX_ONE;
                    launch = 1'b1;
                end
            end
            ST_INTERNAL: begin
                // exactly one state, then move on
                idx_d = idx_q + IDX_ONE;
                launch = 1'b1;
            end
            default: begin
                // unused state code: give up the bus and fall back to idle
                state_d = ST_IDLE;
                req_d = 1'b0;
                lock_d = 1'b0;
            end
        endcase
        if (launch) begin
            unique case (nextStep)
                STEP_END: begin
                    // last step ended: release the bus and flag completion
                    state_d = ST_IDLE;
                    req_d = 1'b0;
                    write_d = 1'b0;
                    word_d = 1'b0;
                    target_d = TGT_RESET;
                    lock_d = 1'b0;
                    done_d = (state_q != ST_IDLE);
                end
                STEP_INTERNAL: begin
                    // no strobe; an earlier lock would still hold here
                    state_d = ST_INTERNAL;
                    req_d = 1'b0;
                    intOp_d = 1'b1;
                    target_d = TGT_RESET;
                    write_d = 1'b0;
                    word_d = 1'b0;
                end
                default: begin
                    state_d = ST_BUS;
                    req_d = 1'b1;
                    write_d = (nextStep == STEP_WR_EA_B);
                    word_d = !(nextStep inside {STEP_RD_EA_B, STEP_RD_EA_B_LOCK,
                                                STEP_WR_EA_B});
                    target_d = stepTarget(nextStep);
                    // lock stays up from a locked cycle until the next starts
                    lock_d = (nextStep inside {STEP_RD_EA_B_LOCK,
                                               STEP_RD_NEXT_LOCK});
                end
            endcase
        end
        // busy has a flop of its own so that seqBusy is not a state decode
        busy_d = (state_d != ST_IDLE);
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    // every register runs on every edge; reset is synchronous
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            group_q <= GRP_BIT_REG;
            mode_q <= MODE_POINTER;
            rmw_q <= 1'b0;
            idx_q <= IDX_RESET;
            accept_q <= 1'b0;
            req_q <= 1'b0;
            write_q <= 1'b0;
            word_q <= 1'b0;
            target_q <= TGT_RESET;
            lock_q <= 1'b0;
            intOp_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            group_q <= group_d;
            mode_q <= mode_d;
            rmw_q <= rmw_d;
            idx_q <= idx_d;
            accept_q <= accept_d;
            req_q <= req_d;
            write_q <= write_d;
            word_q <= word_d;
            target_q <= target_d;
            lock_q <= lock_d;
            intOp_q <= intOp_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    // ***************************************************************
    // outputs, all straight from flip-flops
    // ***************************************************************
    // no input reaches an output without passing a register
    assign instrAccept = accept_q;
    assign busReq = req_q;
    assign busWrite = write_q;
    assign busWord = word_q;
    assign busTarget = target_q;
    assign busLock = lock_q;
    assign internalOp = intOp_q;
    assign seqBusy = busy_q;
    assign instrDone = done_q;

endmodule // cbs_cpu_bus_cycle_sequencer

//--- dv/cbs_bus_ctrl_model.sv
// behavioural bus controller that ends the sequencer's bus cycles
`timescale 1ns/1ps
module cbs_bus_ctrl_model (
    input wire logic clk_sys,          // system clock
    input wire logic nrst,             // synchronous reset, active low
    input wire logic busReq,           // cycle requested by the sequencer
    input wire logic [3:0] waitCycles, // extra states before a cycle ends
    output logic busDone               // one-cycle end of the current cycle
);
    logic [3:0] stateCnt_q;
    // count states of the running cycle; a new cycle starts after each end
    always @(posedge clk_sys) begin
        if (!nrst || !busReq || busDone) stateCnt_q <= 4'h0;
        else stateCnt_q <= stateCnt_q + 4'h1;
    end
    // driven off the falling edge so the sequencer samples a settled level
    always @(negedge clk_sys) begin
        busDone <= nrst && busReq && (stateCnt_q == waitCycles);
    end
endmodule // cbs_bus_ctrl_model

//--- dv/cbs_seq_chk.sv
// concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
module cbs_seq_chk
    import cbs_pkg::*;
(
    input wire logic clk_sys,          // system clock
    input wire logic nrst,             // reset, active low
    input wire logic instrValid,       // instruction offered
    input wire cbs_group_t instrGroup, // instruction class
    input wire logic instrRmw,         // memory write-back form
    input wire cbs_mode_t instrMode,   // addressing mode
    input wire logic busDone,          // cycle ended
    input wire logic instrAccept,      // instruction taken
    input wire logic busReq,           // cycle requested
    input wire logic busWrite,         // write cycle
    input wire logic busWord,          // word size
    input wire logic [2:0] busTarget,  // target selector
    input wire logic busLock,          // locked cycle
    input wire logic internalOp,       // internal state
    input wire logic seqBusy,          // sequencing
    input wire logic instrDone         // sequence finished
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // locked next-word read being ended
    sequence s_lock_next_end;
        busReq && busLock && busWord && !busWrite && busTarget == TGT_NEXT && busDone;
    endsequence
    // unlocked byte write-back to the operand
    sequence s_writeback;
        busReq && busWrite && !busWord && !busLock && busTarget == TGT_EA;
    endsequence
    AST_TAKE: assert property (instrValid && !seqBusy
        |=> instrAccept && seqBusy && (busReq || internalOp)) else $error("instruction not taken");
    AST_REFUSE: assert property (seqBusy |=> !instrAccept)
        else $error("instruction taken while busy");
    AST_HOLD: assert property (busReq && !busDone
        |=> busReq && $stable({busWrite, busWord, busTarget, busLock})) else $error("cycle dropped");
    // a locked cycle that closes the instruction has no successor to keep the bus for
    AST_LOCK_HELD: assert property (busReq && busLock && busDone
        |=> instrDone || (busReq && !internalOp)) else $error("bus released after locked cycle");
    AST_WB_ORDER: assert property (s_lock_next_end
        |=> (s_writeback or instrDone)) else $error("bad step after locked next read");
    // only the first state of a write-back follows the locked read directly
    AST_WB_CAUSE: assert property (busReq && $rose(busWrite)
        |-> $past(busLock) && $past(busTarget) == TGT_NEXT) else $error("write without lock");
    AST_INT_STEP: assert property (internalOp
        |-> !busReq ##1 busReq && busWord && !busWrite && busTarget == TGT_EA)
        else $error("internal state not followed by target read");
    AST_INT_CAUSE: assert property (internalOp
        |-> $past(busDone) && $past(busTarget) == TGT_2ND) else $error("internal state misplaced");
    AST_BYTE_EA: assert property (busReq && !busWord |-> busTarget == TGT_EA)
        else $error("byte cycle off operand");
    AST_DONE: assert property (instrDone
        |-> !seqBusy && !busReq && $past(busDone) && $past(busReq)) else $error("stray done");
endmodule // cbs_seq_chk
bind cbs_cpu_bus_cycle_sequencer cbs_seq_chk chk (.clk_sys, .nrst, .instrValid, .instrGroup,
    .instrRmw, .instrMode, .busDone, .instrAccept, .busReq, .busWrite, .busWord, .busTarget,
    .busLock, .internalOp, .seqBusy, .instrDone);

//--- dv/cbs_cpu_bus_cycle_sequencer_tb.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
module cbs_cpu_bus_cycle_sequencer_tb;
    import cbs_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic instrValid = 1'b0;
    cbs_group_t instrGroup = GRP_BRANCH_D8;
    logic instrRmw = 1'b0;
    cbs_mode_t instrMode = MODE_POINTER;
    logic [3:0] waitCycles = 4'h0;
    logic busDone, instrAccept, busReq, busWrite, busWord, busLock, internalOp, seqBusy, instrDone;
    logic [2:0] busTarget;
    logic [5:0] trace[$];
    logic [5:0] exp[$];
    int fails = 0;
    int samples_checked = 0;
    int accepts = 0;
    always #4 clk_sys = ~clk_sys;
    cbs_cpu_bus_cycle_sequencer dut (.clk_sys(clk_sys), .nrst(nrst), .instrValid(instrValid),
        .instrGroup(instrGroup), .instrRmw(instrRmw), .instrMode(instrMode), .busDone(busDone),
        .instrAccept(instrAccept), .busReq(busReq), .busWrite(busWrite), .busWord(busWord),
        .busTarget(busTarget), .busLock(busLock), .internalOp(internalOp), .seqBusy(seqBusy),
        .instrDone(instrDone));
    cbs_bus_ctrl_model bus (.clk_sys(clk_sys), .nrst(nrst), .busReq(busReq),
        .waitCycles(waitCycles), .busDone(busDone));
    // ******************************************************
    // trace: every ended cycle as {write, word, lock, target}; 3f = internal state
    // ******************************************************
    always @(posedge clk_sys) begin
        if (nrst && busReq && busDone) trace.push_back({busWrite, busWord, busLock, busTarget});
        if (nrst && internalOp) trace.push_back(6'h3f);
        if (nrst && instrAccept) accepts++;
    end
    function automatic logic [5:0] cy(input logic w, input logic wd, input logic lk,
        input logic [2:0] t);
        return {w, wd, lk, t};
    endfunction
    task automatic check_code(input string what, input logic [5:0] e, input logic [5:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_count(input string what, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            fails++;
            $display("[ERR] %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // offer one instruction, optionally holding the offer while busy, then compare the trace
    task automatic run_instr(input cbs_group_t g, input logic rmw, input cbs_mode_t m,
        input logic hold);
        int n;
        trace.delete();
        accepts = 0;
        n = 0;
        @(negedge clk_sys);
        instrValid = 1'b1;
        instrGroup = g;
        instrRmw = rmw;
        instrMode = m;
        while (instrDone !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            if (!hold && instrAccept === 1'b1) instrValid = 1'b0;
            n++;
        end
        instrValid = 1'b0;
        if (n >= 200) begin
            fails++;
            tally_and_finish();
        end
        check_count("accepts", 1, accepts);
        check_count("cycle count", exp.size(), trace.size());
        foreach (exp[i]) begin
            check_code("cycle", exp[i], (i < trace.size()) ? trace[i] : 6'h00);
        end
    endtask
    task automatic t_branch;
        exp = '{cy(0, 1, 0, TGT_NEXT), cy(0, 1, 0, TGT_EA)};
        run_instr(GRP_BRANCH_D8, 1'b0, MODE_POINTER, 1'b0);
        waitCycles = 4'h2;
        exp = '{cy(0, 1, 0, TGT_2ND), 6'h3f, cy(0, 1, 0, TGT_EA)};
        run_instr(GRP_BRANCH_D16, 1'b0, MODE_POINTER, 1'b1);
        run_instr(GRP_BRANCH_D16, 1'b1, MODE_ABS32, 1'b0);
        $display("test branch done");
    endtask
    task automatic t_bit_reg;
        exp = '{cy(0, 1, 0, TGT_NEXT)};
        run_instr(GRP_BIT_REG, 1'b1, MODE_ABS16, 1'b1);
        waitCycles = 4'h0;
        run_instr(GRP_BIT_REG, 1'b0, MODE_POINTER, 1'b0);
        $display("test bit_reg done");
    endtask
    // every addressing mode in both read-only and modify forms, controller speed varied
    task automatic t_bit_mem;
        for (int r = 0; r < 2; r++) begin
            for (int m = 0; m < 4; m++) begin
                exp = '{cy(0, 1, 0, TGT_2ND)};
                if (m >= 2) exp.push_back(cy(0, 1, 0, TGT_3RD));
                if (m == 3) exp.push_back(cy(0, 1, 0, TGT_4TH));
                exp.push_back(cy(0, 0, r[0], TGT_EA));
                exp.push_back(cy(0, 1, 1, TGT_NEXT));
                if (r == 1) exp.push_back(cy(1, 0, 0, TGT_EA));
                waitCycles = 4'(m);
                run_instr(GRP_BIT_MEM, r[0], cbs_mode_t'(m), m[0]);
            end
        end
        check_count("modify abs32 length", 6, trace.size());
        $display("test bit_mem done");
    endtask
    // reset lands in the middle of a locked operand read
    task automatic t_reset_mid;
        waitCycles = 4'h3;
        @(negedge clk_sys);
        instrValid = 1'b1;
        instrGroup = GRP_BIT_MEM;
        instrRmw = 1'b1;
        instrMode = MODE_ABS32;
        @(negedge clk_sys);
        instrValid = 1'b0;
        repeat (14) @(negedge clk_sys);
        nrst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check_code("idle after reset", 6'h00,
            {busReq, busLock, seqBusy, internalOp, instrAccept, instrDone});
        nrst = 1'b1;
        waitCycles = 4'h0;
        exp = '{cy(0, 1, 0, TGT_NEXT)};
        run_instr(GRP_BIT_REG, 1'b0, MODE_POINTER, 1'b0);
        $display("test reset_mid done");
    endtask
    initial begin
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        t_branch();
        t_bit_reg();
        t_bit_mem();
        t_reset_mid();
        tally_and_finish();
    end
endmodule // cbs_cpu_bus_cycle_sequencer_tb
